//--- saci_defines.svh
// Constants of the serial converter control block: field positions,
// reset values and timing counts. Assumes a 200 MHz core clock.
//
// Contract
// - Order bit 0 sends MSB first, 1 LSB first
// - New order applies from the following cycle only
// - Format 0 gives plain unsigned result codes
// - Format 1 gives signed codes, MSB is sign
// - Format applies to the conversion this cycle starts
// - Done high in reset and during sampling
// - Done rises on latch, restarting the cycle
// - First bit at done rise or select fall
// - Output forced zero while converting
// - Each falling clock edge advances to next bit
// - Twelve-bit result, MSB justified, length trims or pads
// - Sixteen-bit pads lead in LSB-first, trail otherwise
// - Select high floats output, then clock ignored
// - Select low resets after debounce interval
// - Select aborts; previous result kept for next cycle
// - Address 1110 enters power-down at fourth fall
// - Power-down skips conversion, keeps result buffer
// - Start in power-down until other address arrives
// - Sample from fourth fall, hold at last fall
// - Addresses 0000 to 1010 pick analog inputs
// - Addresses 1011 to 1101 pick reference voltages
// - Top four command bits carry next conversion address
// - Length bits pick 8, 12 or 16 bits
`ifndef SACI_DEFINES_SVH
`define SACI_DEFINES_SVH

// ----------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------
`define SACI_ADDR_HI       7
`define SACI_ADDR_LO       4
`define SACI_LEN_HI_BIT    3
`define SACI_LEN_LO_BIT    2
`define SACI_ORDER_BIT     1
`define SACI_FORMAT_BIT    0
`define SACI_ADDR_PWRDN    4'he
`define SACI_CMD_BITS      4'h8

// ----------------------------------------------------------------------
// Lengths and frame positions (in falling transfer-clock edges)
// ----------------------------------------------------------------------
`define SACI_LEN_8         5'h08
`define SACI_LEN_12        5'h0c
`define SACI_LEN_16        5'h10
`define SACI_FALL_SAMPLE   5'h04
`define SACI_FALL_LEN_OK   5'h06
`define SACI_WORD_TOP      5'h0f

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SACI_RST_RESULT    12'h000
`define SACI_RST_LEN       5'h0c

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SACI_CLK_MHZ       200
`define SACI_CONV_TIME_NS  2000
`define SACI_DEB_TIME_NS   100
`define SACI_CONV_CYC      (((`SACI_CONV_TIME_NS * `SACI_CLK_MHZ) + 999) / 1000)
`define SACI_DEB_CYC       (((`SACI_DEB_TIME_NS * `SACI_CLK_MHZ) + 999) / 1000)
`define SACI_CONV_CNT_W    9
`define SACI_DEB_CNT_W     5

`endif

//--- saci_pkg.sv
// Types of the serial converter control block.
// Assumes saci_defines.svh holds all numeric constants.
package saci_pkg;

  // --------------------------------------------------------------------
  // Sequencer states, Gray along reset -> transfer -> convert
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    SACI_ST_RST  = 2'b00,
    SACI_ST_IO   = 2'b01,
    SACI_ST_CONV = 2'b11
  } saci_state_t;

endpackage : saci_pkg

//--- saci_core.sv
// Control and sequencing logic of a 12-bit serial converter.
// Assumes the transfer clock arrives as its own clock and stands still
// outside frames; the analog array supplies a code at end of conversion.
`include "saci_defines.svh"

module saci_core
  import saci_pkg::*;
(
  // Core clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Serial link pins
  input  wire logic        i_io_clk,
  input  wire logic        i_select_n,
  input  wire logic        i_sdi,
  output logic             o_sdo,
  output logic             o_sdo_oe,
  output logic             o_eoc,
  // Analog array side
  input  wire logic [11:0] i_conv_code,
  output logic      [3:0]  o_mux_sel,
  output logic             o_sample_en,
  output logic             o_power_down
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic                         link_rst_q;
  logic [7:0]                   cmd_q;
  logic [3:0]                   rise_cnt_q;
  logic [4:0]                   fall_bin_q;
  logic [4:0]                   fall_gray_q;
  logic [4:0]                   fall_inc;
  logic [4:0]                   gray_s1_q;
  logic [4:0]                   gray_s2_q;
  logic [4:0]                   fall_cnt;
  logic                         sel_s1_q;
  logic                         sel_s2_q;
  logic                         sel_stable_q;
  logic                         sel_low;
  logic [`SACI_DEB_CNT_W-1:0]   deb_cnt_q;
  saci_state_t                  state_q;
  saci_state_t                  state_d;
  logic [`SACI_CONV_CNT_W-1:0]  conv_cnt_q;
  logic                         conv_done;
  logic                         frame_end;
  logic [4:0]                   len_cur;
  logic [4:0]                   len_prev_q;
  logic [4:0]                   len_use;
  logic                         order_q;
  logic                         fmt_q;
  logic                         pd_q;
  logic [11:0]                  result_q;
  logic [15:0]                  word16;
  logic [4:0]                   idx;
  logic [4:0]                   pos;
  logic                         sdo_d;
  logic                         addr_pd;
  logic [11:0]                  result_d;
  logic [`SACI_CONV_CNT_W-1:0]  eoc_low_cnt_q;

  // --------------------------------------------------------------------
  // Link domain: command capture and falling-edge count
  // --------------------------------------------------------------------
  // Each rising edge puts its bit in its final place, MSB first, so the
  // address is whole after four bits and the length after six
  always_ff @(posedge i_io_clk or posedge link_rst_q) begin
    if (link_rst_q) begin
      cmd_q      <= 8'h00;
      rise_cnt_q <= 4'h0;
    end else if (rise_cnt_q < `SACI_CMD_BITS) begin
      cmd_q[~rise_cnt_q[2:0]] <= i_sdi;
      rise_cnt_q <= rise_cnt_q + 4'h1;
    end
  end

  assign fall_inc = (fall_bin_q < `SACI_LEN_16) ? fall_bin_q + 5'h01 : fall_bin_q;

  // Count kept in Gray too, so the core sees one changing bit per edge
  always_ff @(negedge i_io_clk or posedge link_rst_q) begin
    if (link_rst_q) begin
      fall_bin_q  <= 5'h00;
      fall_gray_q <= 5'h00;
    end else begin
      fall_bin_q  <= fall_inc;
      fall_gray_q <= fall_inc ^ (fall_inc >> 1);
    end
  end

  // --------------------------------------------------------------------
  // Crossings into the core domain
  // --------------------------------------------------------------------
  // Gray count through two flops
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      gray_s1_q <= 5'h00;
      gray_s2_q <= 5'h00;
    end else begin
      gray_s1_q <= fall_gray_q;
      gray_s2_q <= gray_s1_q;
    end
  end

  // Back to binary, one bit per generate step
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_gray2bin
      assign fall_cnt[gi] = ^gray_s2_q[4:gi];
    end
  endgenerate

  // Select pin through two flops; idles deselected
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
    end else begin
      sel_s1_q <= i_select_n;
      sel_s2_q <= sel_s1_q;
    end
  end

  // Debounce: a level counts only after it holds for the whole interval
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      deb_cnt_q    <= '0;
      sel_stable_q <= 1'b1;
    end else if (sel_s2_q == sel_stable_q) begin
      deb_cnt_q    <= '0;
    end else if (deb_cnt_q == `SACI_DEB_CNT_W'(`SACI_DEB_CYC - 1)) begin
      deb_cnt_q    <= '0;
      sel_stable_q <= sel_s2_q;
    end else begin
      deb_cnt_q    <= deb_cnt_q + `SACI_DEB_CNT_W'(1);
    end
  end

  assign sel_low = ~sel_stable_q;

  // --------------------------------------------------------------------
  // Frame decode
  // --------------------------------------------------------------------
  // The command bits are read only once the count shows they settled
  always_comb begin
    unique case ({cmd_q[`SACI_LEN_HI_BIT], cmd_q[`SACI_LEN_LO_BIT]})
      2'b01:   len_cur = `SACI_LEN_8;
      2'b11:   len_cur = `SACI_LEN_16;
      default: len_cur = `SACI_LEN_12;
    endcase
  end

  assign addr_pd   = cmd_q[`SACI_ADDR_HI:`SACI_ADDR_LO] == `SACI_ADDR_PWRDN;
  // Host keeps the frame exactly the selected length
  assign frame_end = (state_q == SACI_ST_IO) && (fall_cnt >= `SACI_LEN_8)
                     && (fall_cnt == len_cur);
  assign conv_done = (state_q == SACI_ST_CONV)
                     && (conv_cnt_q == `SACI_CONV_CNT_W'(`SACI_CONV_CYC - 1));

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SACI_ST_RST: begin
        // Waits for the link count to read zero before a new frame
        if (sel_low && (fall_cnt == 5'h00)) begin
          state_d = SACI_ST_IO;
        end
      end
      SACI_ST_IO: begin
        if (frame_end) begin
          state_d = (pd_q || addr_pd) ? SACI_ST_RST : SACI_ST_CONV;
        end
      end
      SACI_ST_CONV: begin
        if (conv_done) begin
          state_d = SACI_ST_RST;
        end
      end
      default: state_d = SACI_ST_RST;
    endcase
    // Select raised aborts any frame or conversion
    if (!sel_low) begin
      state_d = SACI_ST_RST;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= SACI_ST_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // Link logic stays in reset outside frames, so stray clocks do nothing
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      link_rst_q <= 1'b1;
    end else begin
      link_rst_q <= state_d != SACI_ST_IO;
    end
  end

  // Conversion timer
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      conv_cnt_q <= '0;
    end else if (state_q == SACI_ST_CONV) begin
      conv_cnt_q <= conv_cnt_q + `SACI_CONV_CNT_W'(1);
    end else begin
      conv_cnt_q <= '0;
    end
  end

  // --------------------------------------------------------------------
  // Settings carried from one frame to the next
  // --------------------------------------------------------------------
  // Order and format latch only at a completed frame, never mid-frame
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      order_q    <= 1'b0;
      fmt_q      <= 1'b0;
      len_prev_q <= `SACI_RST_LEN;
    end else if (frame_end) begin
      order_q    <= cmd_q[`SACI_ORDER_BIT];
      fmt_q      <= cmd_q[`SACI_FORMAT_BIT];
      len_prev_q <= len_cur;
    end
  end

  // Power-down is the state after power-on; decided at fourth fall
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pd_q <= 1'b1;
    end else if ((state_q == SACI_ST_IO) && (fall_cnt >= `SACI_FALL_SAMPLE)) begin
      pd_q <= addr_pd;
    end
  end

  // Mux address and sampling switch
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_mux_sel   <= 4'h0;
      o_sample_en <= 1'b0;
    end else if ((state_d == SACI_ST_IO) && (fall_cnt >= `SACI_FALL_SAMPLE)) begin
      o_mux_sel   <= cmd_q[`SACI_ADDR_HI:`SACI_ADDR_LO];
      o_sample_en <= !addr_pd;
    end else begin
      o_sample_en <= 1'b0;
    end
  end

  // Next result, shared by the latch and the serial output so that the
  // first bit of a new result leaves together with the rise of done
  always_comb begin
    result_d = result_q;
    if (conv_done && sel_low) begin
      result_d = fmt_q ? {~i_conv_code[11], i_conv_code[10:0]}
                       : i_conv_code;
    end
  end

  // Result latch; an aborted conversion leaves the old result in place
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      result_q <= `SACI_RST_RESULT;
    end else begin
      result_q <= result_d;
    end
  end

  // --------------------------------------------------------------------
  // Serial output
  // --------------------------------------------------------------------
  // Length bits are not known until the sixth edge; before that the last
  // frame's length is assumed, which may garble one LSB-first frame
  assign len_use = ((state_q == SACI_ST_IO) && (fall_cnt >= `SACI_FALL_LEN_OK))
                   ? len_cur : len_prev_q;
  // Next-state terms: output register loads the new word at done's rise
  assign word16  = {result_d, 4'h0};
  assign idx     = (state_q == SACI_ST_IO) ? fall_cnt : 5'h00;
  assign pos     = order_q ? (`SACI_LEN_16 - len_use + idx)
                           : (`SACI_WORD_TOP - idx);
  assign sdo_d   = (state_d != SACI_ST_CONV) && (idx < len_use)
                   && word16[pos[3:0]];

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_sdo        <= 1'b0;
      o_sdo_oe     <= 1'b0;
      o_eoc        <= 1'b1;
      o_power_down <= 1'b1;
    end else begin
      o_sdo        <= sdo_d;
      o_sdo_oe     <= ~sel_s2_q;
      o_eoc        <= state_d != SACI_ST_CONV;
      o_power_down <= pd_q;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  // Cycles spent with done low; bounds a conversion without a long
  // repetition inside a property
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      eoc_low_cnt_q <= '0;
    end else if (!o_eoc) begin
      eoc_low_cnt_q <= eoc_low_cnt_q + `SACI_CONV_CNT_W'(1);
    end else begin
      eoc_low_cnt_q <= '0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  AST_EOC_HIGH_OUTSIDE: assert property (
    (state_q != SACI_ST_CONV) |-> o_eoc)
    else $error("done low outside a conversion");
  AST_FRAME_STARTS_CONV: assert property (
    (frame_end && !pd_q && !addr_pd && sel_low) |=> !o_eoc ##1 !o_sdo)
    else $error("frame end did not start a conversion");
  AST_SDO_ZERO_CONV: assert property (
    (!o_eoc && $past(!o_eoc)) |-> !o_sdo)
    else $error("serial output not zero while converting");
  AST_CONV_LENGTH: assert property (
    $fell(o_eoc) && sel_low |-> !o_eoc [*8])
    else $error("conversion ended too early");
  AST_PD_NO_CONV: assert property (
    (frame_end && (pd_q || addr_pd)) |=> o_eoc [*2])
    else $error("conversion ran in power-down");
  AST_UNSIGNED: assert property (
    (conv_done && sel_low && !fmt_q) |=> result_q == $past(i_conv_code))
    else $error("unsigned result wrong");
  AST_SIGNED: assert property (
    (conv_done && sel_low && fmt_q) |=>
      (result_q[11] != $past(i_conv_code[11])) &&
      (result_q[10:0] == $past(i_conv_code[10:0])))
    else $error("signed result wrong");
  AST_ORDER_STABLE: assert property (
    (state_q == SACI_ST_IO) && !frame_end |=> $stable(order_q))
    else $error("order changed inside a frame");
  AST_OE_OFF: assert property (
    sel_s2_q |=> !o_sdo_oe)
    else $error("output driven while deselected");
  AST_ABORT_KEEPS: assert property (
    !sel_low |=> $stable(result_q))
    else $error("result changed during abort");
  AST_MSB_PAD: assert property (
    (state_q == SACI_ST_IO) && !order_q && (len_use == `SACI_LEN_16)
      && (fall_cnt >= `SACI_LEN_12) && (fall_cnt < `SACI_LEN_16) |=> !o_sdo)
    else $error("trailing pad bit not zero");
  AST_CONV_BOUND: assert property (
    eoc_low_cnt_q <= `SACI_CONV_CNT_W'(`SACI_CONV_CYC))
    else $error("conversion ran too long");
  AST_MUX_HELD: assert property (
    !o_eoc |-> $stable(o_mux_sel))
    else $error("input address changed while converting");
  AST_SAMPLE_EOC_HIGH: assert property (
    o_sample_en |-> o_eoc)
    else $error("done low while sampling");
  AST_PD_NO_CONVERT: assert property (
    o_power_down |-> o_eoc)
    else $error("conversion while powered down");

  COV_CONVERSION: cover property ($rose(o_eoc) && sel_low);
  COV_POWER_DOWN: cover property ($rose(pd_q));
  COV_ABORT: cover property ((state_q == SACI_ST_CONV) && !sel_low);
  COV_LEN16_LSB: cover property (frame_end && order_q && (len_cur == `SACI_LEN_16));
  COV_PD_FRAME: cover property (frame_end && addr_pd);

endmodule : saci_core

//--- saci_host_model.sv
// Host serial port model: select, transfer clock and command bits.
// Assumes the device answers 2-3 core cycles (10-15 ns) after each fall.
module saci_host_model (
  // Core clock, aligns select changes
  input  wire logic i_clk,
  // Device pins
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  input  wire logic i_sample_en,
  output logic      o_io_clk,
  output logic      o_select_n,
  output logic      o_sdi
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] rx_q;
  logic [15:0] se_q;
  int          fall_cnt;

  // Idle levels: clock parked low, device deselected
  initial begin
    o_io_clk   = 1'b0;
    o_select_n = 1'b1;
    o_sdi      = 1'b0;
    rx_q       = '0;
    se_q       = '0;
    fall_cnt   = 0;
  end

  // ----------------------------------------------------------------------
  // Capture after each fall
  // ----------------------------------------------------------------------
  // 5 ns lies well after the previous fall's update and before this one's
  always @(negedge o_io_clk) begin
    #5;
    fall_cnt++;
    rx_q = {rx_q[14:0], (i_sdo_oe === 1'b1) ? i_sdo : 1'bx};
    se_q[fall_cnt[3:0]] = i_sample_en;
  end

  // Select is changed on the core clock edge
  task select(input logic v);
    @(posedge i_clk);
    o_select_n <= v;
  endtask : select

  // One transfer of exactly n clocks, also in power-down
  task frame(input logic [7:0] cmd, input int n);
    rx_q     = '0;
    se_q     = '0;
    fall_cnt = 0;
    #3.3;
    for (int k = 0; k < n; k++) begin
      o_sdi = (k < 8) ? cmd[7-k] : 1'b0;
      #7.5 o_io_clk = 1'b1;
      #7.5 o_io_clk = 1'b0;
    end
    o_sdi = 1'b0;
    #12;
  endtask : frame
endmodule : saci_host_model

//--- saci_core_test.sv
// Self-checking bench of the serial converter control block.
// Assumes saci_host_model drives the link; an analog model answers here.
`include "saci_defines.svh"

module saci_core_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        i_clk;
  logic        i_reset;
  logic        io_clk;
  logic        select_n;
  logic        sdi;
  logic        o_sdo;
  logic        o_sdo_oe;
  logic        o_eoc;
  logic [11:0] i_conv_code;
  logic [3:0]  o_mux_sel;
  logic        o_sample_en;
  logic        o_power_down;
  int          errors;
  int          num_checks;
  int          cycles = 0;
  logic [7:0]  cmds [11] = '{8'hb0, 8'hc0, 8'hd1, 8'h5e, 8'h7c, 8'h14,
                             8'he4, 8'h06, 8'h04, 8'ha0, 8'h20};

  saci_core dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_io_clk(io_clk), .i_select_n(select_n),
    .i_sdi(sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_eoc(o_eoc),
    .i_conv_code(i_conv_code), .o_mux_sel(o_mux_sel), .o_sample_en(o_sample_en),
    .o_power_down(o_power_down)
  );

  saci_host_model host (
    .i_clk(i_clk), .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe), .i_sample_en(o_sample_en),
    .o_io_clk(io_clk), .o_select_n(select_n), .o_sdi(sdi)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Ideal code per address; references give their fixed values
  function automatic logic [11:0] code_of(input logic [3:0] a);
    case (a)
      4'hb:    return 12'h800;
      4'hc:    return 12'h000;
      4'hd:    return 12'hfff;
      default: return {a, ~a, a};
    endcase
  endfunction : code_of

  // Expected word, first bit sent at bit n-1
  function automatic logic [15:0] exp_word(input logic [11:0] r, input logic lsb, input int n);
    logic [15:0] w;
    logic [15:0] v;
    w = {r, 4'h0} >> (16 - n);
    v = '0;
    for (int i = 0; i < n; i++) v[i] = lsb ? w[n-1-i] : w[i];
    return v;
  endfunction : exp_word

  task tick;
    @(posedge i_clk);
    #1;
  endtask : tick

  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // Clock and analog array; the code follows the selected input
  initial begin
    i_clk       = 1'b0;
    i_conv_code = 12'h000;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) i_conv_code <= code_of(o_mux_sel);

  // Hang guard, well above eleven frames of about 500 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [11:0] res;
    logic [11:0] k;
    logic        lsb;
    logic [7:0]  c;
    int          n;
    int          t;
    errors  = 0;
    num_checks = 0;
    i_reset = 1'b1;
    res     = `SACI_RST_RESULT;
    lsb     = 1'b0;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    tick;
    check("power_down_start", 1, o_power_down);
    check("eoc_reset", 1, o_eoc);
    host.select(1'b0);
    repeat (40) tick;
    for (int j = 0; j < 11; j++) begin
      c = cmds[j];
      n = (c[3:2] == 2'b01) ? 8 : (c[3:2] == 2'b11) ? 16 : 12;
      host.frame(c, n);
      check("rx_word", exp_word(res, lsb, n), host.rx_q);
      if (c[7:4] == `SACI_ADDR_PWRDN) begin
        check("sample_pd", 0, host.se_q[5]);
        repeat (10) tick;
        check("power_down", 1, o_power_down);
      end else begin
        check("mux_sel", c[7:4], o_mux_sel);
        check("sample_early", 0, host.se_q[2]);
        check("sample_late", 1, host.se_q[5]);
        for (t = 0; t < 20 && o_eoc !== 1'b0; t++) tick;
        check("eoc_fall", 0, o_eoc);
        check("sdo_converting", 0, o_sdo);
        if (j == 9) begin
          // Abort mid-conversion: the old result must survive
          host.select(1'b1);
          repeat (30) tick;
          check("sdo_oe_off", 0, o_sdo_oe);
          host.select(1'b0);
          repeat (40) tick;
          check("eoc_after_abort", 1, o_eoc);
          check("sdo_oe_on", 1, o_sdo_oe);
        end else begin
          for (t = 0; t < 450 && o_eoc !== 1'b1; t++) tick;
          check("eoc_low_len", 1, (t >= 398 && t <= 402));
          k = code_of(c[7:4]);
          res = {k[11] ^ c[0], k[10:0]};
          check("power_up", 0, o_power_down);
          repeat (10) tick;
        end
      end
      lsb = c[1];
    end
    summarize();
  end
endmodule : saci_core_test
